// File: rtl/pbseq_pkg.sv
// Shared constants for the pushbutton power sequencer
package pbseq_pkg;
  // System clock and prescaled timebase
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;

  // Interval counter width in bits, counting ticks
  localparam int TW = 14;

  // Intervals in milliseconds, as specified
  localparam int PB_ON_MS = 200;
  localparam int LONG_MS = 10000;
  localparam int DEB_MS = 50;
  localparam int HOLD_MS = 1000;
  localparam int RST_DELAY_MS = 200;
  localparam int PD_DELAY_MS = 50;

  // Same intervals as tick counts
  localparam logic [TW-1:0] PB_ON_TICKS = TW'(PB_ON_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] LONG_TICKS = TW'(LONG_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] DEB_TICKS = TW'(DEB_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] HOLD_TICKS = TW'(HOLD_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] RST_TICKS = TW'(RST_DELAY_MS * 1000 / TICK_US);
  localparam logic [TW-1:0] PD_TICKS = TW'(PD_DELAY_MS * 1000 / TICK_US);

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_GLOBAL = 6'h00;
  localparam logic [5:0] IDX_CH_FIRST = 6'h01;
  localparam logic [5:0] IDX_CH_LAST = 6'h08;
  localparam logic [5:0] IDX_STATUS = 6'h10;

  // Global register fields and reset value
  localparam int GLB_RESET_ALL_BIT = 7;
  localparam int GLB_IGNORE_EN_BIT = 4;
  localparam logic [7:0] GLB_RST = 8'h00;

  // Channel register fields and reset value pieces
  localparam int CH_EN_BIT = 7;
  localparam int CH_MODE_BIT = 6;
  localparam int CH_PHASE_LSB = 4;
  localparam logic [3:0] CH_REF_RST = 4'hC;

  // Status register fields
  localparam int ST_POWER_ON_BIT = 0;
  localparam int ST_HARD_BIT = 1;
  localparam int ST_RESET_OUT_BIT = 2;
  localparam int ST_CH_ON_LSB = 8;
  localparam int ST_POWER_GOOD_LSB = 16;

  // Largest combined stage
  localparam int GROUP_MAX = 4;

  // Pushbutton state machine, Gray coded along off -> window -> on
  typedef enum logic [1:0] {
    PB_OFF = 2'b00,
    PB_WINDOW = 2'b01,
    PB_ON = 2'b11
  } pb_state_e;
endpackage

// File: rtl/interval_timer.sv
// Tick-driven interval timer that restarts whenever its run input drops
`timescale 1ns/1ps
module interval_timer
  import pbseq_pkg::*;
#(
  parameter int W = TW
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Control
  input wire logic tick,
  input wire logic run,
  input wire logic [W-1:0] limit,
  // Result
  output logic done
);
  logic [W-1:0] cnt_r;

  // Count ticks while running; saturate at the limit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (!run) begin
      cnt_r <= '0;
    end else if (tick && cnt_r != limit) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Done only while still running, so a release cancels it at once
  assign done = run && (cnt_r == limit);
endmodule

// File: rtl/pb_power_sequencer.sv
// Pushbutton power sequencer with channel enables and a Wishbone register file
// How it works
// - Off state holds power_on low; 200ms pushbutton low raises it.
// - power_on stays high 10s, then falls unless kill went high meanwhile.
// - After the window, kill low beyond 50ms debounce drops power_on.
// - Kill input is ignored while the pushbutton is held low; kill low still blocks new channel power-up.
// - In on state, 10s pushbutton hold drops power_on without hard reset.
// - Long-press power-off latches the interrupt output low.
// - Press of 50ms to 10s pulls interrupt low only while held.
// - Kill low over 50ms starts hard reset, held until 1s after release.
// - Kill low in off state also forces hard reset.
// - Global reset command gives 1s hard reset and returns to off.
// - Kill low blocks any new channel power-up.
// - Any hard reset clears all channel register bits to zero.
// - Reset output rises 200ms after all enabled channels are power-good.
// - Kill hard reset from on state powers channels down 50ms later.
// - Pushbutton interrupts set no readable status bit.
// - A channel turns on from its enable pin or register enable bit.
// - Without register enable, enable pin low powers the channel down.
// - Ignore-pins bit makes every enable pin read as low.
// - Lowest channel of a combined stage is master; its register governs.
// - Only the master enable pin controls a combined stage.
// - Up to four adjacent channels group; channel one never slave.
// - Supply low clears bus state and restores register defaults.
// - Serial port handles up to 400kHz; host keeps below that.
// - Global register: reset command in bit 7, ignore-pins in bit 4.
// - Channel register: enable in top bit, then mode, phase, reference.
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module pb_power_sequencer
  import pbseq_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pushbutton and kill
  input wire logic pushbutton_n,
  input wire logic kill_n,
  // Supply monitor, high while the internal supply is below 1V
  input wire logic supply_low,
  // Channel side
  input wire logic [NCH-1:0] en_pin,
  input wire logic [NCH-1:0] power_good,
  input wire logic [NCH-1:0] feedback_input,
  output logic [NCH-1:0] ch_enable,
  output logic [NCH-1:0] ch_mode,
  output logic [2*NCH-1:0] ch_phase,
  output logic [4*NCH-1:0] ch_ref,
  // System outputs
  output logic power_on,
  output logic irq_n,
  output logic reset_out_n
);
  // Bus timing is independent of the serial rate; up to 400kHz is fine

  // Timebase
  logic [31:0] div_r;
  logic tick;

  // Registers
  logic [7:0] glb_r;
  logic [7:0] ch_r [NCH];
  logic ack_r;
  logic [31:0] dat_r;

  // Control state
  pb_state_e state_r;
  pb_state_e state_nxt;
  logic hard_r;
  logic from_on_r;
  logic kill_seen_r;
  logic irq_lat_r;
  logic [NCH-1:0] on_r;
  logic [NCH-1:0] on_nxt;
  logic [NCH-1:0] mode_r;
  logic [2*NCH-1:0] phase_r;
  logic [4*NCH-1:0] ref_r;

  // Timer results
  logic pb_on_done;
  logic pb_short_done;
  logic pb_long_done;
  logic win_done;
  logic kill_deb;
  logic hold_done;
  logic pd_done;
  logic rst_done;

  // Prescaler: the tick period stands in for the timing capacitor
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= '0;
    end else if (div_r == 32'(TICK_CYCLES - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 32'h1;
    end
  end
  assign tick = (div_r == 32'(TICK_CYCLES - 1));

  // Bus decode
  wire [5:0] idx = adr_i[7:2];
  wire req = cyc_i && stb_i;
  wire wr_go = req && we_i && ack_r && sel_i[0] && !supply_low;
  wire hit_glb = (idx == IDX_GLOBAL);
  wire hit_ch = (idx >= IDX_CH_FIRST) && (idx <= IDX_CH_LAST);
  wire hit_st = (idx == IDX_STATUS);
  wire [2:0] ch_sel = 3'(idx - IDX_CH_FIRST);
  wire reset_cmd = wr_go && hit_glb && dat_i[GLB_RESET_ALL_BIT];
  wire ignore_en = glb_r[GLB_IGNORE_EN_BIT];

  // Pushbutton and kill conditions
  wire pb_low = !pushbutton_n;
  wire kill_low = !kill_n && pushbutton_n;
  wire in_off = (state_r == PB_OFF);
  wire kill_cause = kill_deb || (in_off && kill_low);
  wire off_force = hard_r && (!from_on_r || pd_done);

  // Reset output waits for every enabled channel to be good
  wire all_good = (|on_r) && ((power_good | ~on_r) == {NCH{1'b1}});

  // Status word; pushbutton interrupts deliberately absent
  wire [31:0] status_word = {8'h00, power_good, on_r, 5'h00, reset_out_n, hard_r, power_on};

  // Read data selection; unmapped addresses read zero
  wire [31:0] rd_mux = hit_glb ? {24'h0, glb_r} :
                       hit_ch ? {24'h0, ch_r[ch_sel]} :
                       hit_st ? status_word : 32'h0;

  // Intervals
  interval_timer #(.W(TW)) t_pb_on (
    .sys_clk(sys_clk), .rst_b(rst_b), .tick(tick),
    .run(pb_low && in_off), .limit(PB_ON_TICKS), .done(pb_on_done)
  );
  interval_timer #(.W(TW)) t_pb_short (
    .sys_clk(sys_clk), .rst_b(rst_b), .tick(tick),
    .run(pb_low && !in_off), .limit(DEB_TICKS), .done(pb_short_done)
  );
  interval_timer #(.W(TW)) t_pb_long (
    .sys_clk(sys_clk), .rst_b(rst_b), .tick(tick),
    .run(pb_low && !in_off), .limit(LONG_TICKS), .done(pb_long_done)
  );
  interval_timer #(.W(TW)) t_window (
    .sys_clk(sys_clk), .rst_b(rst_b), .tick(tick),
    .run(state_r == PB_WINDOW), .limit(LONG_TICKS), .done(win_done)
  );
  interval_timer #(.W(TW)) t_kill (
    .sys_clk(sys_clk), .rst_b(rst_b), .tick(tick),
    .run(kill_low), .limit(DEB_TICKS), .done(kill_deb)
  );
  interval_timer #(.W(TW)) t_hold (
    .sys_clk(sys_clk), .rst_b(rst_b), .tick(tick),
    .run(hard_r && !kill_cause && !reset_cmd), .limit(HOLD_TICKS), .done(hold_done)
  );
  interval_timer #(.W(TW)) t_pd (
    .sys_clk(sys_clk), .rst_b(rst_b), .tick(tick),
    .run(hard_r && from_on_r), .limit(PD_TICKS), .done(pd_done)
  );
  interval_timer #(.W(TW)) t_rst (
    .sys_clk(sys_clk), .rst_b(rst_b), .tick(tick),
    .run(all_good), .limit(RST_TICKS), .done(rst_done)
  );

  // Pushbutton state machine next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PB_OFF: begin
        if (pb_on_done && !hard_r) begin
          state_nxt = PB_WINDOW;
        end
      end
      PB_WINDOW: begin
        if (reset_cmd || pb_long_done) begin
          state_nxt = PB_OFF;
        end else if (win_done) begin
          state_nxt = kill_seen_r ? PB_ON : PB_OFF;
        end
      end
      PB_ON: begin
        if (reset_cmd || pb_long_done || kill_deb) begin
          state_nxt = PB_OFF;
        end
      end
      default: begin
        state_nxt = PB_OFF;
      end
    endcase
  end

  // State, window memory and latched interrupt
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= PB_OFF;
      kill_seen_r <= 1'b0;
      irq_lat_r <= 1'b0;
    end else if (supply_low) begin
      state_r <= PB_OFF;
      kill_seen_r <= 1'b0;
      irq_lat_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Kill high during the window keeps power_on up after it
      kill_seen_r <= (state_r == PB_WINDOW) && (kill_seen_r || (kill_n && pushbutton_n));
      // Held until the next pushbutton power-up
      if (state_r != PB_OFF && state_nxt == PB_OFF && pb_long_done) begin
        irq_lat_r <= 1'b1;
      end else if (state_r == PB_OFF && state_nxt == PB_WINDOW) begin
        irq_lat_r <= 1'b0;
      end
    end
  end

  // Hard reset: held while kill is the cause, then one hold interval
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hard_r <= 1'b0;
      from_on_r <= 1'b0;
    end else if (supply_low) begin
      hard_r <= 1'b0;
      from_on_r <= 1'b0;
    end else if (kill_cause || reset_cmd) begin
      hard_r <= 1'b1;
      if (!hard_r) begin
        from_on_r <= !in_off && !reset_cmd;
      end
    end else if (hold_done) begin
      hard_r <= 1'b0;
      from_on_r <= 1'b0;
    end
  end

  // Master of each channel; a chain stops after four members
  logic [2:0] mst [NCH];
  always_comb begin
    int grp;
    grp = 1;
    mst[0] = 3'd0;
    for (int i = 1; i < NCH; i++) begin
      if (feedback_input[i] && grp < GROUP_MAX) begin
        mst[i] = mst[i-1];
        grp = grp + 1;
      end else begin
        mst[i] = 3'(i);
        grp = 1;
      end
    end
  end

  // Effective pins and channel requests
  wire [NCH-1:0] pin_eff = ignore_en ? '0 : en_pin;
  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      // Pin or register of the master, never a slave's own
      on_nxt[k] = (pin_eff[mst[k]] || ch_r[mst[k]][CH_EN_BIT])
                  && !off_force
                  && (on_r[k] || (kill_n && !hard_r));
    end
  end

  // Channel drive, taken from the master register fields
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      on_r <= '0;
      mode_r <= '0;
      phase_r <= '0;
      ref_r <= '0;
    end else begin
      on_r <= supply_low ? '0 : on_nxt;
      for (int k = 0; k < NCH; k++) begin
        mode_r[k] <= ch_r[mst[k]][CH_MODE_BIT];
        phase_r[2*k +: 2] <= ch_r[mst[k]][CH_PHASE_LSB +: 2];
        ref_r[4*k +: 4] <= ch_r[mst[k]][3:0];
      end
    end
  end

  // Register file; defaults give each pair of channels the next phase
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      glb_r <= GLB_RST;
      for (int k = 0; k < NCH; k++) begin
        ch_r[k] <= {2'b00, 2'(k / 2), CH_REF_RST};
      end
    end else if (supply_low) begin
      glb_r <= GLB_RST;
      for (int k = 0; k < NCH; k++) begin
        ch_r[k] <= {2'b00, 2'(k / 2), CH_REF_RST};
      end
    end else begin
      // Command bit is an action, so it never reads back as set
      if (wr_go && hit_glb) begin
        glb_r <= {1'b0, dat_i[6:0]};
      end
      for (int k = 0; k < NCH; k++) begin
        if (off_force || reset_cmd) begin
          ch_r[k] <= 8'h00;
        end else if (wr_go && hit_ch && ch_sel == 3'(k)) begin
          ch_r[k] <= dat_i[7:0];
        end
      end
    end
  end

  // Wishbone answer: ack one cycle after the request, read data latched then
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else if (supply_low) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= req && !ack_r;
      if (req && !ack_r) begin
        dat_r <= rd_mux;
      end
    end
  end

  // Outputs
  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign ch_enable = on_r;
  assign ch_mode = mode_r;
  assign ch_phase = phase_r;
  assign ch_ref = ref_r;
  assign power_on = (state_r != PB_OFF);
  // Transient low for a press past debounce but short of the long hold
  assign irq_n = !(irq_lat_r || (pb_short_done && !pb_long_done));
  assign reset_out_n = rst_done;
endmodule

// File: dv/user_host_model.sv
// Pushbutton user, kill-driving host and converter power-good model
`timescale 1ns/1ps
module user_host_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Requests from the bench
  input wire logic press,
  input wire logic kill,
  // Pins toward the sequencer
  input wire logic [7:0] ch_enable,
  output logic pushbutton_n,
  output logic kill_n,
  output logic [7:0] power_good
);
  logic [7:0] ramp_r;
  // Levels move just after an edge; power good trails enable by two cycles like a soft start
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pushbutton_n <= 1'b1;
      kill_n <= 1'b1;
      ramp_r <= 8'h00;
      power_good <= 8'h00;
    end else begin
      pushbutton_n <= !press;
      kill_n <= !kill;
      ramp_r <= ch_enable;
      power_good <= ramp_r & ch_enable;
    end
  end
endmodule

// File: dv/pb_power_sequencer_asserts.sv
// Port-level assertions for the pushbutton power sequencer
`timescale 1ns/1ps
module pb_power_sequencer_asserts
  import pbseq_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus handshake
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Pins
  input wire logic pushbutton_n,
  input wire logic kill_n,
  input wire logic supply_low,
  input wire logic [NCH-1:0] power_good,
  input wire logic [NCH-1:0] ch_enable,
  input wire logic power_on,
  input wire logic irq_n,
  input wire logic reset_out_n
);
  localparam int PB_LIM = (int'(PB_ON_TICKS) - 2) * TICK_CYCLES;
  localparam int LP_LIM = (int'(PB_ON_TICKS) + int'(LONG_TICKS) + 3) * TICK_CYCLES;
  localparam int KL_LIM = (int'(DEB_TICKS) + int'(PD_TICKS) + 3) * TICK_CYCLES;
  localparam int RS_LIM = (int'(RST_TICKS) - 2) * TICK_CYCLES;
  int press_cnt;
  int kill_cnt;
  int good_cnt;
  logic all_good;
  assign all_good = (power_good & ch_enable) == ch_enable;
  // Run lengths; kill is only counted with the button up, since a held button masks it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      press_cnt <= 0;
      kill_cnt <= 0;
      good_cnt <= 0;
    end else begin
      press_cnt <= pushbutton_n ? 0 : press_cnt + 1;
      kill_cnt <= (kill_n || !pushbutton_n) ? 0 : kill_cnt + 1;
      good_cnt <= all_good ? good_cnt + 1 : 0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b || supply_low);
  sequence wb_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  // Six quiet cycles leave room for input synchronisers
  sequence quiet_button;
    pushbutton_n [*6];
  endsequence
  ack_once_a: assert property (wb_req |=> ack_o ##1 !ack_o)
    else $error("bus ack missing or too long");
  off_hold_a: assert property (quiet_button ##0 !power_on |=> !power_on)
    else $error("power on rose without a press");
  pb_rise_a: assert property ($rose(power_on) |-> press_cnt >= PB_LIM || $past(press_cnt, 4) >= PB_LIM)
    else $error("power on rose after too short a press");
  long_drop_a: assert property (press_cnt == LP_LIM |-> !power_on)
    else $error("long press left power on high");
  irq_short_a: assert property (quiet_button ##0 power_on |-> irq_n)
    else $error("transient interrupt outlived the press");
  irq_latch_a: assert property (quiet_button ##0 (!irq_n && !power_on) |=> !irq_n)
    else $error("latched interrupt released");
  kill_block_a: assert property (!kill_n [*3] |=> (ch_enable & ~$past(ch_enable)) == '0)
    else $error("channel powered up with kill low");
  kill_off_a: assert property (kill_cnt >= KL_LIM |-> ch_enable == '0)
    else $error("channels still on under kill");
  rst_delay_a: assert property ($rose(reset_out_n) |-> good_cnt >= RS_LIM)
    else $error("reset output released early");
  rst_fall_a: assert property (!all_good |-> ##[0:4] !reset_out_n)
    else $error("reset output high with a channel not good");
endmodule
bind pb_power_sequencer pb_power_sequencer_asserts #(.TICK_CYCLES(TICK_CYCLES), .NCH(NCH)) watch_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .pushbutton_n(pushbutton_n), .kill_n(kill_n), .supply_low(supply_low), .power_good(power_good),
  .ch_enable(ch_enable), .power_on(power_on), .irq_n(irq_n), .reset_out_n(reset_out_n)
);

// File: dv/pushbutton_power_sequencer_bench.sv
// Self-checking bench for the pushbutton power sequencer
`timescale 1ns/1ps
module pushbutton_power_sequencer_bench
  import pbseq_pkg::*;
;
  localparam int TC = 4;
  logic sys_clk, rst_b, cyc_i, stb_i, we_i, supply_low, press, kill, ack_o;
  logic pushbutton_n, kill_n, power_on, irq_n, reset_out_n;
  logic [7:0] adr_i, en_pin, feedback_input, ch_enable, power_good, r, p, fb, d, ch_mode;
  logic [15:0] ch_phase;
  logic [7:0] regs [8];
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, q, ch_ref;
  int fail_count, num_checks;
  int mi;
  pb_power_sequencer #(.TICK_CYCLES(TC), .NCH(8)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pushbutton_n(pushbutton_n),
    .kill_n(kill_n), .supply_low(supply_low), .en_pin(en_pin), .power_good(power_good),
    .feedback_input(feedback_input), .ch_enable(ch_enable),
    .ch_mode(ch_mode), .ch_phase(ch_phase), .ch_ref(ch_ref),
    .power_on(power_on), .irq_n(irq_n), .reset_out_n(reset_out_n)
  );
  user_host_model partner (
    .sys_clk(sys_clk), .rst_b(rst_b), .press(press), .kill(kill), .ch_enable(ch_enable),
    .pushbutton_n(pushbutton_n), .kill_n(kill_n), .power_good(power_good)
  );
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog sized a little above the planned run of about 96k cycles
  initial begin
    #(110_000 * 20);
    fail_count++;
    finish_test();
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle: request held until ack is sampled, data taken at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'hF;
    adr_i <= a;
    dat_i <= wd;
    do @(posedge sys_clk); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n * TC) @(posedge sys_clk);
  endtask
  // Enable latency is not fixed, so wait a bounded time for the expected pattern
  task automatic settle(input logic [7:0] e);
    for (int n = 0; n < 20 && ch_enable !== e; n++) @(posedge sys_clk);
  endtask
  // Channels stay off through the hold, then the pins bring them back
  task automatic hold_release();
    ticks(985);
    chk(ch_enable, 8'h00);
    ticks(30);
    chk(ch_enable, 8'h03);
  endtask
  // Each channel follows its group master; a group closes after GROUP_MAX members
  function automatic logic [7:0] exp_en(logic [7:0] pin, logic [7:0] ren, logic [7:0] slv, logic ign);
    int m;
    int c;
    logic [7:0] e;
    m = 0;
    c = 0;
    for (int i = 0; i < 8; i++) begin
      c = (i == 0 || !slv[i] || c == GROUP_MAX) ? 1 : c + 1;
      if (c == 1) m = i;
      e[i] = (pin[m] & !ign) | ren[m];
    end
    return e;
  endfunction
  // Lowest channel of the group that holds channel i, grouped as in exp_en
  function automatic int master_of(int i, logic [7:0] slv);
    int m;
    int c;
    m = 0;
    c = 0;
    for (int j = 0; j <= i; j++) begin
      c = (j == 0 || !slv[j] || c == GROUP_MAX) ? 1 : c + 1;
      if (c == 1) m = j;
    end
    return m;
  endfunction
  initial begin
    {rst_b, cyc_i, stb_i, we_i, supply_low, press, kill} = 7'h00;
    {adr_i, en_pin, feedback_input} = 24'h0;
    sel_i = 4'hF;
    dat_i = 32'h0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    void'($urandom(70));
    // Reset values, then an unmapped word that must read zero
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      chk(q, i == 0 ? GLB_RST : {26'h0, 2'((i - 1) / 2), CH_REF_RST});
    end
    wb(1'b1, 8'h80, 32'hFF);
    wb(1'b0, 8'h80, 32'h0);
    chk(q, 32'h0);
    // Random pins, register enables and groupings, odd passes with pins ignored
    for (int k = 0; k < 8; k++) begin
      r = 8'($urandom);
      p = 8'($urandom);
      fb = 8'($urandom);
      wb(1'b1, 8'h00, {27'h0, k[0], 4'h0});
      wb(1'b0, 8'h00, 32'h0);
      chk(q, {27'h0, k[0], 4'h0});
      for (int i = 0; i < 8; i++) begin
        d = {r[i], 7'($urandom)};
        regs[i] = d;
        wb(1'b1, 8'(i * 4 + 4), {24'h0, d});
        wb(1'b0, 8'(i * 4 + 4), 32'h0);
        chk(q, {24'h0, d});
      end
      en_pin <= p;
      feedback_input <= fb;
      settle(exp_en(p, r, fb, k[0]));
      chk(ch_enable, exp_en(p, r, fb, k[0]));
      // Field outputs are registered, so let the new grouping settle first
      repeat (2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        mi = master_of(i, fb);
        chk(ch_mode[i], regs[mi][CH_MODE_BIT]);
        chk(ch_phase[2*i +: 2], regs[mi][CH_PHASE_LSB +: 2]);
        chk(ch_ref[4*i +: 4], regs[mi][3:0]);
      end
    end
    // Supply dip restores defaults
    wb(1'b1, 8'h04, 32'hFF);
    supply_low <= 1'b1;
    en_pin <= 8'h03;
    feedback_input <= 8'h00;
    repeat (3) @(posedge sys_clk);
    supply_low <= 1'b0;
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0C);
    chk(ch_mode, 8'h00);
    chk(ch_phase, 16'hFA50);
    chk(ch_ref, {8{CH_REF_RST}});
    ticks(195);
    chk(reset_out_n, 1'b0);
    ticks(15);
    chk(reset_out_n, 1'b1);
    // Reset-all command
    wb(1'b1, 8'h00, 32'h80);
    settle(8'h00);
    chk(ch_enable, 8'h00);
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk(q[ST_HARD_BIT], 1'b1);
    hold_release();
    // Kill while off
    kill <= 1'b1;
    ticks(3);
    chk(ch_enable, 8'h00);
    kill <= 1'b0;
    hold_release();
    // Press to power up, then a short press inside the window
    press <= 1'b1;
    ticks(190);
    chk(power_on, 1'b0);
    ticks(20);
    chk(power_on, 1'b1);
    press <= 1'b0;
    ticks(5);
    press <= 1'b1;
    ticks(45);
    chk(irq_n, 1'b1);
    ticks(13);
    chk(irq_n, 1'b0);
    wb(1'b0, 8'h40, 32'h0);
    // Whole status word: on, good, reset released, nothing for the held button
    chk(q, (32'h3 << ST_POWER_GOOD_LSB) | (32'h3 << ST_CH_ON_LSB) | (32'h1 << ST_RESET_OUT_BIT) | 32'h1);
    press <= 1'b0;
    ticks(3);
    chk(irq_n, 1'b1);
    // Past the end of the window, so kill seen high must have kept power on
    ticks(9950);
    chk(power_on, 1'b1);
    // Kill after the window: debounce, then channels dropped 50ms into the hard reset
    kill <= 1'b1;
    ticks(45);
    chk(power_on, 1'b1);
    ticks(15);
    chk(power_on, 1'b0);
    ticks(35);
    chk(ch_enable, 8'h03);
    ticks(15);
    chk(ch_enable, 8'h00);
    kill <= 1'b0;
    hold_release();
    // Long press with kill ignored while held
    press <= 1'b1;
    ticks(210);
    chk(power_on, 1'b1);
    kill <= 1'b1;
    ticks(150);
    kill <= 1'b0;
    chk(ch_enable, 8'h03);
    ticks(9820);
    chk(power_on, 1'b1);
    ticks(40);
    chk(power_on, 1'b0);
    chk(ch_enable, 8'h03);
    press <= 1'b0;
    ticks(5);
    chk(irq_n, 1'b0);
    finish_test();
  end
endmodule
